// ---- verilog/dma_chan_pkg.sv ----
// dma_chan_pkg: register map, field positions and codes of one dma channel
// assumes an apb slave with 32-bit data and byte addresses
`default_nettype none

package dma_chan_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_SRC = 12'h004;
  localparam logic [11:0] OFF_DST = 12'h008;
  localparam logic [11:0] OFF_CNT = 12'h00c;

  // ---------------------------------------------------------------
  // control word field positions and reset values
  // ---------------------------------------------------------------
  localparam int RUN_POS = 0;
  localparam int MODE_POS = 1;
  localparam int BLOCK_POS = 4;
  localparam int BURST_POS = 5;
  localparam int WID_POS = 6;
  localparam int SRC_STEP_POS = 8;
  localparam int DST_STEP_POS = 10;
  localparam int IRQ_EN_POS = 12;
  localparam int ACK_LEN_POS = 13;
  localparam int BUSY_POS = 31;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam int CNT_WIDTH = 24;
  localparam int BURST_LEN = 4;

  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_SW = 3'h0;
  localparam logic [2:0] MODE_EXT = 3'h1;
  localparam logic [2:0] MODE_SER_TX = 3'h2;
  localparam logic [2:0] MODE_SER_RX = 3'h3;
  localparam logic [2:0] MODE_CIPH_IN = 3'h4;
  localparam logic [2:0] MODE_CIPH_OUT = 3'h5;
  localparam logic [1:0] STEP_INC = 2'h0;
  localparam logic [1:0] STEP_DEC = 2'h1;
  localparam logic [1:0] STEP_FIX = 2'h2;
  localparam logic [1:0] WID_BYTE = 2'h0;
  localparam logic [1:0] WID_HALF = 2'h1;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_READ, ST_WRITE} xfer_st_t;

endpackage

`default_nettype wire

// ---- verilog/ack_stretch.sv ----
// ack_stretch: holds the external acknowledge high for len + 1 cycles
// assumes start is a one-cycle pulse on pclk; a new start reloads the length
`default_nettype none

module ack_stretch
  import dma_chan_pkg::*;
#(
  parameter int LEN_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [LEN_W-1:0] len,
  output logic ack
);

  generate
    if (LEN_W < 1)
    begin : g_chk
      $error("ack_stretch: LEN_W must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic ack;
    logic [LEN_W-1:0] left;
    logic [LEN_W-1:0] len_seen;
    logic [LEN_W:0] high_cnt;
  } ack_state_t;

  ack_state_t q;
  ack_state_t d;

  // ---------------------------------------------------------------
  // stretch counter
  // ---------------------------------------------------------------
  always_comb
  begin
    d = q;
    if (start)
    begin
      d.ack = 1'b1;
      d.left = len;
      d.len_seen = len;
      d.high_cnt = (LEN_W+1)'(1);
    end
    else if (q.ack)
    begin
      if (q.left == '0)
      begin
        d.ack = 1'b0;
      end
      else
      begin
        d.left = q.left - LEN_W'(1);
        d.high_cnt = q.high_cnt + (LEN_W+1)'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign ack = q.ack;

  a_ack_length: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(q.ack) |-> $past(q.high_cnt) == {1'b0, $past(q.len_seen)} + (LEN_W+1)'(1))
    else $error("acknowledge length differs from count field plus one");

endmodule

`default_nettype wire

// ---- verilog/dma_channel_control.sv ----
// dma_channel_control: control word, address stepping and transfer engine of one dma channel
// assumes an apb master on pclk, a same-clock memory port and peripheral request,
// and an asynchronous external request pin
//
// Behaviour
// - addresses step by 1, 2 or 4 bytes per transfer for byte, half-word, word.
// - source step field: 00 increment, 01 decrement, 10 hold.
// - source step field ignored in serial receive and cipher output modes.
// - destination step field: 00 increment, 01 decrement, 10 hold.
// - destination step field ignored in serial transmit and cipher input modes.
// - completion raises the interrupt only when its enable bit is set.
// - stopping by clearing run raises no completion interrupt.
// - external acknowledge stays high for count field plus one cycles.
// - read-only busy bit 31 is set while the channel runs, else zero.
// - bit 0 starts the operation when written 1, stops it when 0.
// - single mode: one request per transfer; block mode: one per operation.
// - bit 5 selects four-datum bursts except in serial modes, else one datum per transfer.
// - a burst reads four source addresses then writes four destinations.
// - count drops by the width per datum; remainder moves singly.
`default_nettype none

module dma_channel_control
  import dma_chan_pkg::*;
#(
  parameter int CNT_W = CNT_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_xfer_request,
  output logic ext_xfer_ack,
  input wire logic periph_xfer_request,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  output logic done_irq,
  output logic active_flag
);

  generate
    if (CNT_W < 4 || CNT_W > 31)
    begin : g_chk
      $error("dma_channel_control: CNT_W must lie in 4..31");
    end
  endgenerate

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic run_bit;
    logic [2:0] mode;
    logic single_block_select;
    logic quad_burst_enable;
    logic [1:0] transfer_width;
    logic [1:0] src_step_mode;
    logic [1:0] dst_step_mode;
    logic done_irq_enable;
    logic [3:0] ack_stretch_count;
    logic active_flag;
    logic [31:0] src;
    logic [31:0] dst;
    logic [CNT_W-1:0] cnt;
    xfer_st_t st;
    logic [1:0] beat;
    logic [1:0] last_beat;
    logic [3:0][31:0] buffer;
    logic block_go;
    logic req_s1;
    logic req_s2;
    logic req_prev;
    logic ack_go;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic done_irq;
  } chan_state_t;

  chan_state_t q;
  chan_state_t d;

  logic [2:0] wid;
  logic go;
  logic burst_ok;
  logic src_hold;
  logic dst_hold;
  logic ext_edge;
  logic rd_beat;
  logic wr_beat;
  logic [CNT_W-1:0] cnt_nx;
  logic [31:0] src_nx;
  logic [31:0] dst_nx;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    return a == OFF_CTRL || a == OFF_SRC || a == OFF_DST || a == OFF_CNT;
  endfunction

  function automatic logic [2:0] width_of(input logic [1:0] w);
    logic [2:0] r;
    r = 3'h4;
    if (w == WID_BYTE)
      r = 3'h1;
    else if (w == WID_HALF)
      r = 3'h2;
    return r;
  endfunction

  // reserved step code 11 behaves as hold
  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] dir,
                                            input logic [2:0] w, input logic hold);
    logic [31:0] r;
    r = a;
    if (!hold && dir == STEP_INC)
      r = a + {29'h0, w};
    else if (!hold && dir == STEP_DEC)
      r = a - {29'h0, w};
    return r;
  endfunction

  // ---------------------------------------------------------------
  // decode of the current setting
  // ---------------------------------------------------------------
  always_comb
  begin
    wid = width_of(q.transfer_width);
    src_hold = q.mode == MODE_SER_RX || q.mode == MODE_CIPH_OUT;
    dst_hold = q.mode == MODE_SER_TX || q.mode == MODE_CIPH_IN;
    ext_edge = q.req_s2 && !q.req_prev;
    rd_beat = q.st == ST_READ && mem_ack;
    wr_beat = q.st == ST_WRITE && mem_ack;
    // bursts only where the count still holds four data
    burst_ok = q.quad_burst_enable && q.mode != MODE_SER_TX && q.mode != MODE_SER_RX
               && q.cnt >= CNT_W'(BURST_LEN * wid);
    src_nx = step_addr(q.src, q.src_step_mode, wid, src_hold);
    dst_nx = step_addr(q.dst, q.dst_step_mode, wid, dst_hold);
    cnt_nx = (q.cnt > CNT_W'(wid)) ? q.cnt - CNT_W'(wid) : '0;
    go = 1'b0;
    unique case (q.mode)
      MODE_SW: go = 1'b1;
      MODE_EXT: go = q.single_block_select ? (q.block_go || ext_edge) : ext_edge;
      MODE_SER_TX, MODE_SER_RX, MODE_CIPH_IN, MODE_CIPH_OUT: go = periph_xfer_request;
      default: go = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.pready = 1'b0;
    d.done_irq = 1'b0;
    d.ack_go = 1'b0;
    d.req_s1 = ext_xfer_request;
    d.req_s2 = q.req_s1;
    d.req_prev = q.req_s2;

    // apb: answer in the cycle after setup, no wait states
    if (psel && !penable)
    begin
      d.pready = 1'b1;
      d.pslverr = !is_mapped(paddr);
      d.prdata = '0;
      if (paddr == OFF_CTRL)
        d.prdata = {q.active_flag, 14'h0, q.ack_stretch_count, q.done_irq_enable,
                    q.dst_step_mode, q.src_step_mode, q.transfer_width, q.quad_burst_enable,
                    q.single_block_select, q.mode, q.run_bit};
      else if (paddr == OFF_SRC)
        d.prdata = q.src;
      else if (paddr == OFF_DST)
        d.prdata = q.dst;
      else if (paddr == OFF_CNT)
        d.prdata = {{(32-CNT_W){1'b0}}, q.cnt};
    end

    // register writes; while busy only the run bit may change
    if (psel && penable && pwrite && q.pready)
    begin
      if (paddr == OFF_CTRL)
      begin
        d.run_bit = pwdata[RUN_POS];
        if (!q.active_flag)
        begin
          d.mode = pwdata[MODE_POS +: 3];
          d.single_block_select = pwdata[BLOCK_POS];
          d.quad_burst_enable = pwdata[BURST_POS];
          d.transfer_width = pwdata[WID_POS +: 2];
          d.src_step_mode = pwdata[SRC_STEP_POS +: 2];
          d.dst_step_mode = pwdata[DST_STEP_POS +: 2];
          d.done_irq_enable = pwdata[IRQ_EN_POS];
          d.ack_stretch_count = pwdata[ACK_LEN_POS +: 4];
        end
      end
      else if (paddr == OFF_SRC && !q.active_flag)
        d.src = pwdata;
      else if (paddr == OFF_DST && !q.active_flag)
        d.dst = pwdata;
      else if (paddr == OFF_CNT && !q.active_flag)
        d.cnt = pwdata[CNT_W-1:0];
    end

    // transfer engine
    if (!q.active_flag)
    begin
      if (q.run_bit && q.cnt != '0)
      begin
        d.active_flag = 1'b1;
        d.st = ST_WAIT;
        d.block_go = 1'b0;
      end
      else if (q.run_bit)
        d.run_bit = 1'b0;
    end
    else if (!q.run_bit)
    begin
      // stopped by software: no completion interrupt
      d.active_flag = 1'b0;
      d.st = ST_IDLE;
      d.mem_req = 1'b0;
      d.block_go = 1'b0;
    end
    else
    begin
      unique case (q.st)
        ST_WAIT:
        begin
          if (q.mode == MODE_EXT && q.single_block_select && ext_edge)
            d.block_go = 1'b1;
          if (go)
          begin
            // block mode acknowledges only the request that opened the operation
            d.ack_go = q.mode == MODE_EXT && !q.block_go;
            d.last_beat = burst_ok ? 2'h3 : 2'h0;
            d.beat = 2'h0;
            d.st = ST_READ;
            d.mem_req = 1'b1;
            d.mem_we = 1'b0;
            d.mem_addr = q.src;
          end
        end
        ST_READ:
        begin
          if (mem_ack)
          begin
            d.buffer[q.beat] = mem_rdata;
            d.src = src_nx;
            if (q.beat == q.last_beat)
            begin
              // all reads of the burst done, now the writes
              d.st = ST_WRITE;
              d.beat = 2'h0;
              d.mem_we = 1'b1;
              d.mem_addr = q.dst;
              d.mem_wdata = (q.beat == 2'h0) ? mem_rdata : q.buffer[0];
            end
            else
            begin
              d.beat = q.beat + 2'h1;
              d.mem_addr = src_nx;
            end
          end
        end
        ST_WRITE:
        begin
          if (mem_ack)
          begin
            d.dst = dst_nx;
            d.cnt = cnt_nx;
            if (cnt_nx == '0)
            begin
              d.active_flag = 1'b0;
              d.run_bit = 1'b0;
              d.st = ST_IDLE;
              d.mem_req = 1'b0;
              d.mem_we = 1'b0;
              d.block_go = 1'b0;
              d.done_irq = q.done_irq_enable;
            end
            else if (q.beat == q.last_beat)
            begin
              d.st = ST_WAIT;
              d.mem_req = 1'b0;
              d.mem_we = 1'b0;
            end
            else
            begin
              d.beat = q.beat + 2'h1;
              d.mem_addr = dst_nx;
              d.mem_wdata = q.buffer[q.beat + 2'h1];
            end
          end
        end
        ST_IDLE:
          d.st = ST_WAIT;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.src <= ADDR_RESET;
      q.dst <= ADDR_RESET;
      q.st <= ST_IDLE;
    end
    else
      q <= d;
  end

  // ---------------------------------------------------------------
  // acknowledge stretcher and outputs
  // ---------------------------------------------------------------
  ack_stretch #(
    .LEN_W(4)
  ) u_ack (
    .pclk(pclk),
    .presetn(presetn),
    .start(q.ack_go),
    .len(q.ack_stretch_count),
    .ack(ext_xfer_ack)
  );

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign mem_req = q.mem_req;
  assign mem_we = q.mem_we;
  assign mem_addr = q.mem_addr;
  assign mem_size = q.transfer_width;
  assign mem_wdata = q.mem_wdata;
  assign done_irq = q.done_irq;
  assign active_flag = q.active_flag;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_burst_go;
    q.active_flag && q.run_bit && q.st == ST_WAIT && go && burst_ok;
  endsequence

  sequence s_four_reads;
    q.st == ST_READ && q.last_beat == 2'h3 && q.beat == 2'h0;
  endsequence

  a_src_inc: assert property (
    rd_beat && q.run_bit && !src_hold && q.src_step_mode == STEP_INC
    |=> q.src == $past(q.src) + {29'h0, $past(wid)})
    else $error("source address did not increase by the width");
  a_src_ignored: assert property (
    rd_beat && src_hold |=> $stable(q.src))
    else $error("source address moved in a peripheral-source mode");
  a_dst_dec: assert property (
    wr_beat && q.run_bit && !dst_hold && q.dst_step_mode == STEP_DEC
    |=> q.dst == $past(q.dst) - {29'h0, $past(wid)})
    else $error("destination address did not decrease by the width");
  a_dst_ignored: assert property (
    wr_beat && dst_hold |=> $stable(q.dst))
    else $error("destination address moved in a peripheral-destination mode");
  a_cnt_step: assert property (
    wr_beat && q.run_bit && q.cnt > CNT_W'(wid) |=> q.cnt == $past(q.cnt) - CNT_W'($past(wid)))
    else $error("count did not drop by the width");
  a_irq_done: assert property (
    q.done_irq |-> $past(q.done_irq_enable) && !q.active_flag && q.cnt == '0)
    else $error("interrupt without an enabled completion");
  a_stop_quiet: assert property (
    q.active_flag && !q.run_bit |=> !q.done_irq && !q.active_flag)
    else $error("software stop raised an interrupt or kept busy");
  a_busy_read: assert property (
    psel && !penable && paddr == OFF_CTRL |=> q.prdata[BUSY_POS] == $past(q.active_flag) && q.pready)
    else $error("busy bit read back wrong");
  a_run_start: assert property (
    q.run_bit && !q.active_flag && q.cnt != '0 |=> q.active_flag ##1 q.run_bit || !q.active_flag)
    else $error("run bit did not start the channel");
  a_single_wait: assert property (
    q.active_flag && q.run_bit && q.st == ST_WAIT && q.mode == MODE_EXT
    && !q.single_block_select && !ext_edge |=> q.st == ST_WAIT || !q.active_flag)
    else $error("single mode moved without a request edge");
  a_burst_len: assert property (
    s_burst_go |=> s_four_reads)
    else $error("burst did not set up four reads");
  a_zero_end: assert property (
    wr_beat && q.run_bit && q.cnt <= CNT_W'(wid) |=> !q.active_flag && !q.run_bit && q.st == ST_IDLE)
    else $error("zero count did not end the operation");

endmodule

`default_nettype wire

// ---- bench/mem_partner.sv ----
// mem_partner: memory end of the channel's beat port
// assumes one clock; waits up to stall_max cycles before each ack and logs every completed beat
`default_nettype none

module mem_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [1:0] stall_max,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_cnt;
  logic q_we[$];
  logic [31:0] q_addr[$];
  logic [31:0] q_data[$];

  // ---------------------------------------------------------------
  // beat answer: read data toggles outside an ack so stale data never matches
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_cnt <= 2'h0;
    end
    else if (mem_req && mem_ack)
    begin
      q_we.push_back(mem_we);
      q_addr.push_back(mem_addr);
      q_data.push_back(mem_we ? mem_wdata : mem_rdata);
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt <= 2'($urandom_range(stall_max, 0));
    end
    else if (mem_req && wait_cnt == 2'h0)
    begin
      mem_ack <= 1'b1;
      mem_rdata <= {mem_addr[15:0], ~mem_addr[15:0]};
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt <= (wait_cnt == 2'h0) ? wait_cnt : wait_cnt - 2'h1;
    end
  end
endmodule

`default_nettype wire

// ---- bench/dma_channel_control_bench.sv ----
// dma_channel_control_bench: self-checking bench for one dma channel
// assumes mem_partner on the beat port; the apb master and request pins are driven here
`default_nettype none

module dma_channel_control_bench
  import dma_chan_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errv, mem_req, mem_we, mem_ack;
  logic ext_xfer_request, ext_xfer_ack, periph_xfer_request, done_irq, active_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, mem_addr, mem_wdata, mem_rdata, c, n, sa, da;
  logic [1:0] mem_size, stall_max, wc;
  logic [3:0] len;
  int n_fail = 0;
  int n_tests = 0;
  int n_irq = 0;
  int ack_run = 0;
  int irq0;
  int ack_lens[$];

  dma_channel_control i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_xfer_request(ext_xfer_request), .ext_xfer_ack(ext_xfer_ack),
    .periph_xfer_request(periph_xfer_request), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .done_irq(done_irq), .active_flag(active_flag)
  );
  mem_partner i_mem (
    .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .stall_max(stall_max), .mem_rdata(mem_rdata), .mem_ack(mem_ack)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    if (done_irq === 1'b1)
      n_irq++;
    if (mem_req === 1'b1 && mem_ack === 1'b1)
      chk("beat size", 32'(c[7:6]), 32'(mem_size));
    if (ext_xfer_ack === 1'b1)
      ack_run++;
    else if (ack_run != 0)
    begin
      ack_lens.push_back(ack_run);
      ack_run = 0;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hang(input string what);
    n_fail++;
    $display("ERROR %s expected done seen timeout", what);
    give_verdict();
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
      hang("pready");
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] cw(logic [2:0] m, logic sb, logic fb, logic [1:0] w, logic [1:0] s,
                                     logic [1:0] d, logic ie, logic [3:0] l);
    return {15'h0, l, ie, d, s, w, fb, sb, m, 1'b1};
  endfunction

  function automatic logic [31:0] step(logic [31:0] b, logic [1:0] k, int w, int i);
    return (k == STEP_INC) ? b + i * w : (k == STEP_DEC) ? b - i * w : b;
  endfunction

  task automatic start(input logic [31:0] s, input logic [31:0] d);
    i_mem.q_we.delete();
    i_mem.q_addr.delete();
    i_mem.q_data.delete();
    irq0 = n_irq;
    wr(OFF_SRC, s);
    wr(OFF_DST, d);
    wr(OFF_CNT, n);
    wr(OFF_CTRL, c);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    repeat (2) @(posedge pclk);
    while (active_flag !== 1'b0 && k < 5000)
    begin
      @(posedge pclk);
      k++;
    end
    if (k >= 5000)
      hang("active_flag");
    @(posedge pclk);
  endtask

  // expected beats: groups of reads then writes, burst of four while a whole one fits
  task automatic chk_beats(input logic [31:0] s, input logic [31:0] d);
    int w, m, rem, g, b, i;
    w = 1 << c[7:6];
    m = c[3:1];
    rem = n;
    b = 0;
    while (rem > 0)
    begin
      g = (c[5] && rem >= 4 * w) ? 4 : 1;
      rem -= g * w;
      b += 2 * g;
    end
    chk("beat count", b, i_mem.q_addr.size());
    if (b != i_mem.q_addr.size())
      return;
    rem = n;
    b = 0;
    i = 0;
    while (rem > 0)
    begin
      g = (c[5] && rem >= 4 * w) ? 4 : 1;
      for (int j = 0; j < g; j++)
      begin
        chk("read beat", 32'h0, i_mem.q_we[b + j]);
        chk("write beat", 32'h1, i_mem.q_we[b + g + j]);
        if (m != 3 && m != 5)
          chk("src addr", step(s, c[9:8], w, i + j), i_mem.q_addr[b + j]);
        if (m != 2 && m != 4)
          chk("dst addr", step(d, c[11:10], w, i + j), i_mem.q_addr[b + g + j]);
        if (m < 2 && w == 4)
          chk("moved data", i_mem.q_data[b + j], i_mem.q_data[b + g + j]);
      end
      rem -= g * w;
      b += 2 * g;
      i += g;
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, ext_xfer_request, periph_xfer_request} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    stall_max = 2'h0;
    void'($urandom(715));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_CTRL);
    chk("ctrl reset", CTRL_RESET, rdv);
    wr(OFF_CTRL, 32'h8000_0000);
    rd(OFF_CTRL);
    chk("busy write", 32'h0, rdv);
    rd(12'h010);
    chk("unmapped err", 32'h1, errv);
    chk("unmapped data", 32'h0, rdv);
    for (int i = 0; i < 16; i++)
    begin
      wc = 2'($urandom_range(2, 0));
      c = cw(MODE_SW, 1'b0, 1'($urandom_range(1, 0)), wc, 2'($urandom_range(2, 0)),
             2'($urandom_range(2, 0)), 1'(i % 2), 4'h0);
      if (c[5])
        c[11:8] = 4'h0;
      n = (i == 0) ? 32'h1 : 32'($urandom_range(11, 1)) << wc;
      sa = 32'h1000_0800 + ($urandom & 32'h0000_03f0);
      da = 32'h2000_0800 + ($urandom & 32'h0000_03f0);
      stall_max <= 2'($urandom_range(3, 0));
      start(sa, da);
      wait_idle();
      chk_beats(sa, da);
      chk("irq pulses", c[12], n_irq - irq0);
      rd(OFF_CTRL);
      chk("ctrl done", c & 32'h0001_fffe, rdv);
      rd(OFF_CNT);
      chk("count done", 32'h0, rdv);
    end
    stall_max <= 2'h3;
    c = cw(MODE_SW, 1'b0, 1'b0, WID_HALF, STEP_INC, STEP_INC, 1'b1, 4'h0);
    n = 32'h800;
    start(32'h3000_0000, 32'h3100_0000);
    rd(OFF_CTRL);
    chk("busy bit", 32'h1, rdv[31]);
    chk("busy pin", 32'h1, active_flag);
    wr(OFF_CTRL, c & 32'hffff_fffe);
    wait_idle();
    chk("abort irq", 32'h0, n_irq - irq0);
    chk("abort early", 32'h1, i_mem.q_addr.size() < 2048);
    stall_max <= 2'h0;
    for (int m = 2; m < 8; m++)
    begin
      wc = (m < 4) ? WID_BYTE : 2'h2;
      c = cw(3'(m), 1'b0, 1'b0, wc, STEP_DEC, STEP_DEC, 1'b1, 4'h0);
      n = 32'h3 << wc;
      start(32'h4000_0100, 32'h5000_0100);
      repeat (30) @(posedge pclk);
      chk("idle without request", 32'h0, i_mem.q_addr.size());
      periph_xfer_request <= 1'b1;
      repeat (30) @(posedge pclk);
      if (m > 5)
      begin
        chk("reserved mode", 32'h0, i_mem.q_addr.size());
        wr(OFF_CTRL, 32'h0);
      end
      wait_idle();
      periph_xfer_request <= 1'b0;
      if (m < 6)
        chk_beats(32'h4000_0100, 32'h5000_0100);
    end
    stall_max <= 2'h1;
    for (int li = 0; li < 6; li++)
    begin
      len = (li < 2) ? 4'h0 : (li < 4) ? 4'hf : 4'($urandom_range(14, 1));
      c = cw(MODE_EXT, 1'(li % 2), 1'b0, 2'h2, STEP_INC, STEP_FIX, 1'b1, len);
      n = 32'hc;
      ack_lens.delete();
      start(32'h6000_0000, 32'h7000_0000);
      for (int r = 0; r < ((li % 2) ? 1 : 3); r++)
      begin
        repeat (6) @(posedge pclk);
        ext_xfer_request <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_xfer_request <= 1'b0;
        repeat (40) @(posedge pclk);
        chk("beats per request", (li % 2) ? 32'h6 : 32'(2 * r + 2), i_mem.q_addr.size());
      end
      wait_idle();
      chk_beats(32'h6000_0000, 32'h7000_0000);
      chk("ack pulses", (li % 2) ? 32'h1 : 32'h3, ack_lens.size());
      foreach (ack_lens[j])
        chk("ack length", 32'(len) + 32'h1, ack_lens[j]);
    end
    give_verdict();
  end
endmodule

`default_nettype wire
